// File: pkg/cdb_pkg.sv
// Purpose: Shared constants and types for the character display bus master.
// Assumes: 32-bit APB data, byte addresses, hclk at 200 MHz.
// Notes:   Every offset, field position, reset value and timing step lives here.
package cdb_pkg;

  // ----------------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------------
  localparam int unsigned      ADDR_W          = 12;
  localparam logic [11:0]      OFS_CONFIG      = 12'h000;
  localparam logic [11:0]      OFS_READ_CMD    = 12'h004;
  localparam logic [11:0]      OFS_WRITE_CMD   = 12'h008;

  // ----------------------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------------------
  localparam int unsigned      CFG_ACT_LSB     = 24;
  localparam int unsigned      CFG_INACT_LSB   = 16;
  localparam int unsigned      CFG_SETUP_LSB   = 12;
  localparam int unsigned      CFG_HOLD_LSB    = 8;
  localparam int unsigned      CFG_DMA_BIT     = 2;
  localparam int unsigned      CFG_WIDTH_BIT   = 1;
  localparam int unsigned      CFG_POL_BIT     = 0;
  localparam logic [31:0]      CFG_RESET       = 32'hFFFF_FF00;
  localparam logic [31:0]      CFG_WR_MASK     = 32'hFFFF_FF07;

  // ----------------------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------------------
  localparam int unsigned      CMD_BIT         = 9;
  localparam int unsigned      RS_BIT          = 8;

  // ----------------------------------------------------------------------------
  // Timing: phase length in hclk is (code + 1) shifted left by the step.
  // ----------------------------------------------------------------------------
  localparam int unsigned      CNT_W           = 14;  // Wide enough to hold the longest gap of 8192 clocks.
  localparam int unsigned      ACT_SHIFT       = 1;
  localparam int unsigned      INACT_SHIFT     = 5;

  // ----------------------------------------------------------------------------
  // Write queue
  // ----------------------------------------------------------------------------
  localparam int unsigned      WQ_WIDTH        = 9;
  localparam int unsigned      WQ_DEPTH        = 8;

  // Phases of one display bus transfer.
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SETUP,
    PH_ACTIVE,
    PH_HOLD,
    PH_INACT
  } cdb_phase_t;

endpackage : cdb_pkg

// File: pkg/cdb_queue_if.sv
// Purpose: Carrier between the bus master and its write queue.
// Assumes: Valid and ready handshake on both sides, same clock.
// Notes:   A word moves when valid and ready are both high.
`timescale 1ns/1ps
interface cdb_queue_if #(parameter int unsigned W = 9);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport queue (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
  modport user  (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
endinterface : cdb_queue_if

// File: design/cdb_queue.sv
// Purpose: Parameterised FIFO that holds queued display writes.
// Assumes: Synchronous active-high reset, one clock.
// Notes:   Full and empty come from an occupancy count, never guessed.
`timescale 1ns/1ps
module cdb_queue #(
  parameter int unsigned W = 9,
  parameter int unsigned D = 8
) (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       sys_rst,
  // Queue ports.
  cdb_queue_if.queue     q
);
  localparam int unsigned AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rd_ptr;
    logic [AW-1:0]       wr_ptr;
    logic [AW:0]         count;
  } cdb_queue_state_t;

  cdb_queue_state_t st_ff;
  cdb_queue_state_t nxt_st;
  logic             push;
  logic             pop;

  // Handshake terms seen from both sides.
  assign q.in_ready  = (st_ff.count != (AW+1)'(D));
  assign q.out_valid = (st_ff.count != '0);
  assign q.out_data  = st_ff.mem[st_ff.rd_ptr];
  assign push        = q.in_valid && q.in_ready;
  assign pop         = q.out_valid && q.out_ready;

  // Pointer and count update.
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr_ptr] = q.in_data;
      nxt_st.wr_ptr = (st_ff.wr_ptr == AW'(D-1)) ? '0 : st_ff.wr_ptr + AW'(1);
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == AW'(D-1)) ? '0 : st_ff.rd_ptr + AW'(1);
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - (AW+1)'(1);
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Occupancy never passes the depth.
  AST_QUEUE_BOUND: assert property (@(posedge clk) disable iff (sys_rst)
    st_ff.count <= (AW+1)'(D)) else $error("Queue count above depth.");

endmodule // cdb_queue

// File: design/cdb_display_master.sv
// Purpose: APB slave that runs programmable read and write cycles on a display bus.
// Assumes: Display data inputs are asynchronous and pass two flip-flops.
// Notes:   Queued writes sit in an eight-word FIFO; a full FIFO stalls an APB write that sets write command bit 9.
`timescale 1ns/1ps

// Summary of operation
// - A pending read command starts a display read cycle.
// - Writes start when queued and no read pends; reads win.
// - Hardware clears a command bit once its cycle is done.
// - 8-bit mode one transfer; 4-bit mode two, upper nibble first, upper lines.
// - With DMA enabled, request whenever no write is pending.
// - Strobe active for (code+1)*2 clocks, code in config bits 31:24.
// - Strobe inactive (code+1)*32 clocks before next activation, bits 23:16.
// - Select and data set up code+1 clocks before strobe, bits 15:12.
// - Select and data held code+1 clocks after strobe, bits 11:8.
// - Config bit 1 set gives 8-bit bus, clear gives 4-bit.
// - Config bit 0 set gives active-high strobe, clear active-low.
// - Writing 1 to read bit 9 starts a read; reads 1 until done.
// - Read cycles drive register select from read register bit 8.
// - Read byte lands in read register bits 7:0.
// - Writing 1 to write bit 9 queues a write; reads 1 while pending.
// - Write cycles drive register select from write register bit 8.
// - Write cycles drive write register bits 7:0 on the data lines.
module cdb_display_master #(
  parameter int unsigned QDEPTH = cdb_pkg::WQ_DEPTH
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // DMA request.
  output logic             dma_req,
  // Display bus pins.
  output logic             display_strobe,
  output logic             display_reg_select,
  output logic             display_rw,
  input  wire logic [7:0]  display_data_lines_in,
  output logic      [7:0]  display_data_lines_out,
  output logic      [7:0]  display_data_lines_oe
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    cdb_pkg::cdb_phase_t             phase;
    logic [cdb_pkg::CNT_W-1:0]       cnt;
    logic [31:0]                     cfg;
    logic                            rd_cmd;
    logic                            rd_rs;
    logic [7:0]                      transfer_byte;
    logic [8:0]                      wr_shadow;
    logic                            wr_busy;
    logic                            op_rd;
    logic                            op_rs;
    logic [7:0]                      op_byte;
    logic                            nib;
    logic                            more;
    logic [7:0]                      sync1;
    logic [7:0]                      sync2;
    logic [31:0]                     prdata;
    logic                            pready;
    logic                            pslverr;
    logic                            dma;
    logic                            strobe;
    logic                            rs;
    logic                            rw;
    logic [7:0]                      dout;
    logic [7:0]                      doe;
  } cdb_state_t;

  cdb_state_t                        st_ff;
  cdb_state_t                        nxt_st;
  cdb_queue_if #(.W(cdb_pkg::WQ_WIDTH)) wq();

  logic [3:0]                        setup_code;
  logic [3:0]                        hold_code;
  logic [7:0]                        act_code;
  logic [7:0]                        inact_code;
  logic [cdb_pkg::CNT_W-1:0]         len_setup;
  logic [cdb_pkg::CNT_W-1:0]         len_act;
  logic [cdb_pkg::CNT_W-1:0]         len_hold;
  logic [cdb_pkg::CNT_W-1:0]         len_inact;
  logic                            bus8;
  logic                            pol;
  logic                            wr_pending;
  logic                            setup_ph;
  logic                            access_ph;
  logic                            wr_blocked;

  // ----------------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------------
  // Phase lengths in hclk from the timing codes.
  assign act_code   = st_ff.cfg[cdb_pkg::CFG_ACT_LSB +: 8];
  assign inact_code = st_ff.cfg[cdb_pkg::CFG_INACT_LSB +: 8];
  assign setup_code = st_ff.cfg[cdb_pkg::CFG_SETUP_LSB +: 4];
  assign hold_code  = st_ff.cfg[cdb_pkg::CFG_HOLD_LSB +: 4];
  assign len_setup  = cdb_pkg::CNT_W'(setup_code) + cdb_pkg::CNT_W'(1);
  assign len_hold   = cdb_pkg::CNT_W'(hold_code) + cdb_pkg::CNT_W'(1);
  assign len_act    = (cdb_pkg::CNT_W'(act_code) + cdb_pkg::CNT_W'(1)) << cdb_pkg::ACT_SHIFT;
  assign len_inact  = (cdb_pkg::CNT_W'(inact_code) + cdb_pkg::CNT_W'(1)) << cdb_pkg::INACT_SHIFT;
  assign bus8       = st_ff.cfg[cdb_pkg::CFG_WIDTH_BIT];
  assign pol        = st_ff.cfg[cdb_pkg::CFG_POL_BIT];

  // A write is pending while queued or on the bus.
  assign wr_pending = wq.out_valid || st_ff.wr_busy;

  // APB phases; a write command with a full queue holds off the answer.
  assign setup_ph   = psel && !penable;
  assign access_ph  = psel && penable && st_ff.pready;
  assign wr_blocked = pwrite && (paddr == cdb_pkg::OFS_WRITE_CMD)
                      && pwdata[cdb_pkg::CMD_BIT] && !wq.in_ready;

  // Queue push from the APB write, pop when the engine takes a write.
  assign wq.in_valid = access_ph && pwrite && (paddr == cdb_pkg::OFS_WRITE_CMD)
                       && pwdata[cdb_pkg::CMD_BIT];
  assign wq.in_data  = pwdata[cdb_pkg::RS_BIT:0];
  assign wq.out_ready = (st_ff.phase == cdb_pkg::PH_IDLE) && !st_ff.rd_cmd;

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  // Bus engine, register file and pin drivers.
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = display_data_lines_in;
    nxt_st.sync2 = st_ff.sync1;
    if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - cdb_pkg::CNT_W'(1);
    end
    case (st_ff.phase)
      cdb_pkg::PH_IDLE: begin
        if (st_ff.rd_cmd) begin
          nxt_st.op_rd = 1'b1;
          nxt_st.op_rs = st_ff.rd_rs;
          nxt_st.nib   = 1'b0;
          nxt_st.phase = cdb_pkg::PH_SETUP;
          nxt_st.cnt   = len_setup - cdb_pkg::CNT_W'(1);
        end else if (wq.out_valid) begin
          nxt_st.op_rd   = 1'b0;
          nxt_st.op_rs   = wq.out_data[cdb_pkg::RS_BIT];
          nxt_st.op_byte = wq.out_data[7:0];
          nxt_st.wr_busy = 1'b1;
          nxt_st.nib     = 1'b0;
          nxt_st.phase   = cdb_pkg::PH_SETUP;
          nxt_st.cnt     = len_setup - cdb_pkg::CNT_W'(1);
        end
      end
      cdb_pkg::PH_SETUP: begin
        if (st_ff.cnt == '0) begin
          nxt_st.phase = cdb_pkg::PH_ACTIVE;
          nxt_st.cnt   = len_act - cdb_pkg::CNT_W'(1);
        end
      end
      cdb_pkg::PH_ACTIVE: begin
        if (st_ff.cnt == '0) begin
          // Capture the read data as the strobe ends.
          if (st_ff.op_rd) begin
            if (bus8) begin
              nxt_st.transfer_byte = st_ff.sync2;
            end else if (!st_ff.nib) begin
              nxt_st.transfer_byte[7:4] = st_ff.sync2[7:4];
            end else begin
              nxt_st.transfer_byte[3:0] = st_ff.sync2[7:4];
            end
          end
          nxt_st.phase = cdb_pkg::PH_HOLD;
          nxt_st.cnt   = len_hold - cdb_pkg::CNT_W'(1);
        end
      end
      cdb_pkg::PH_HOLD: begin
        if (st_ff.cnt == '0) begin
          nxt_st.more = !bus8 && !st_ff.nib;
          if (bus8 || st_ff.nib) begin
            if (st_ff.op_rd) begin
              nxt_st.rd_cmd = 1'b0;
            end else begin
              nxt_st.wr_busy = 1'b0;
            end
          end
          nxt_st.phase = cdb_pkg::PH_INACT;
          nxt_st.cnt   = len_inact - cdb_pkg::CNT_W'(1);
        end
      end
      cdb_pkg::PH_INACT: begin
        if (st_ff.cnt == '0) begin
          if (st_ff.more) begin
            nxt_st.nib   = 1'b1;
            nxt_st.more  = 1'b0;
            nxt_st.phase = cdb_pkg::PH_SETUP;
            nxt_st.cnt   = len_setup - cdb_pkg::CNT_W'(1);
          end else begin
            nxt_st.phase = cdb_pkg::PH_IDLE;
          end
        end
      end
      default: begin
        nxt_st.phase = cdb_pkg::PH_IDLE;
      end
    endcase

    // APB write: the set of a command bit lands after the hardware clear.
    if (access_ph && pwrite) begin
      if (paddr == cdb_pkg::OFS_CONFIG) begin
        nxt_st.cfg = pwdata & cdb_pkg::CFG_WR_MASK;
      end else if (paddr == cdb_pkg::OFS_READ_CMD) begin
        nxt_st.rd_rs = pwdata[cdb_pkg::RS_BIT];
        if (pwdata[cdb_pkg::CMD_BIT]) begin
          nxt_st.rd_cmd = 1'b1;
        end
      end else if (paddr == cdb_pkg::OFS_WRITE_CMD) begin
        nxt_st.wr_shadow = pwdata[cdb_pkg::RS_BIT:0];
      end
    end

    // APB answer: ready and read data are prepared one cycle ahead.
    nxt_st.pready  = psel && !(penable && st_ff.pready) && !wr_blocked;
    nxt_st.pslverr = 1'b0;
    if (psel && !(penable && st_ff.pready)) begin
      nxt_st.prdata = '0;
      if (paddr == cdb_pkg::OFS_CONFIG) begin
        nxt_st.prdata = st_ff.cfg;
      end else if (paddr == cdb_pkg::OFS_READ_CMD) begin
        nxt_st.prdata = {22'h0, st_ff.rd_cmd, st_ff.rd_rs, st_ff.transfer_byte};
      end else if (paddr == cdb_pkg::OFS_WRITE_CMD) begin
        nxt_st.prdata = {22'h0, wr_pending, st_ff.wr_shadow};
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end

    // DMA request whenever enabled and no write is pending.
    nxt_st.dma = st_ff.cfg[cdb_pkg::CFG_DMA_BIT] && !wr_pending;

    // Pin drivers follow the next phase and the next polarity, so a polarity write never leaves a stale level.
    nxt_st.strobe = (nxt_st.phase == cdb_pkg::PH_ACTIVE) ? nxt_st.cfg[cdb_pkg::CFG_POL_BIT]
                                                         : !nxt_st.cfg[cdb_pkg::CFG_POL_BIT];
    if (nxt_st.phase == cdb_pkg::PH_IDLE) begin
      nxt_st.rw   = 1'b1;
      nxt_st.doe  = '0;
      nxt_st.dout = '0;
    end else begin
      nxt_st.rs  = nxt_st.op_rs;
      nxt_st.rw  = nxt_st.op_rd;
      if (nxt_st.op_rd) begin
        nxt_st.doe  = '0;
        nxt_st.dout = '0;
      end else if (bus8) begin
        nxt_st.doe  = 8'hFF;
        nxt_st.dout = nxt_st.op_byte;
      end else begin
        nxt_st.doe  = 8'hF0;
        nxt_st.dout = nxt_st.nib ? {nxt_st.op_byte[3:0], 4'h0} : {nxt_st.op_byte[7:4], 4'h0};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  // One register for all state.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff        <= '0;
      st_ff.phase  <= cdb_pkg::PH_IDLE;
      st_ff.cfg    <= cdb_pkg::CFG_RESET;
      st_ff.strobe <= 1'b1;
      st_ff.rw     <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Write queue instance.
  cdb_queue #(.W(cdb_pkg::WQ_WIDTH), .D(QDEPTH)) u_queue (
    .clk     (clk),
    .sys_rst (sys_rst),
    .q       (wq)
  );

  // Outputs straight from flops.
  assign prdata                 = st_ff.prdata;
  assign pready                 = st_ff.pready;
  assign pslverr                = st_ff.pslverr;
  assign dma_req                = st_ff.dma;
  assign display_strobe         = st_ff.strobe;
  assign display_reg_select     = st_ff.rs;
  assign display_rw             = st_ff.rw;
  assign display_data_lines_out = st_ff.dout;
  assign display_data_lines_oe  = st_ff.doe;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  // Counts cycles spent in the current phase.
  logic [cdb_pkg::CNT_W:0] ph_len;
  always_ff @(posedge clk) begin
    if (sys_rst || nxt_st.phase != st_ff.phase) begin
      ph_len <= (cdb_pkg::CNT_W+1)'(1);
    end else begin
      ph_len <= ph_len + (cdb_pkg::CNT_W+1)'(1);
    end
  end

  sequence s_phase_ends(cdb_pkg::cdb_phase_t p);
    st_ff.phase == p && nxt_st.phase != p;
  endsequence

  AST_ACTIVE_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    s_phase_ends(cdb_pkg::PH_ACTIVE) |-> ph_len == {1'b0, len_act}) else $error("Strobe active length wrong.");
  AST_INACT_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    s_phase_ends(cdb_pkg::PH_INACT) |-> ph_len == {1'b0, len_inact}) else $error("Strobe gap length wrong.");
  AST_SETUP_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    s_phase_ends(cdb_pkg::PH_SETUP) |-> ph_len == {1'b0, len_setup}) else $error("Setup length wrong.");
  AST_HOLD_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    s_phase_ends(cdb_pkg::PH_HOLD) |-> ph_len == {1'b0, len_hold}) else $error("Hold length wrong.");
  AST_READ_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.phase == cdb_pkg::PH_IDLE && st_ff.rd_cmd) |=> st_ff.op_rd && !wq.out_ready) else $error("Write ran ahead of read.");
  AST_CMD_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(st_ff.rd_cmd) |-> $past(st_ff.phase) == cdb_pkg::PH_HOLD && st_ff.phase == cdb_pkg::PH_INACT)
    else $error("Read bit cleared at wrong time.");
  AST_STROBE_POL: assert property (@(posedge clk) disable iff (sys_rst)
    display_strobe == ((st_ff.phase == cdb_pkg::PH_ACTIVE) ? pol : !pol)) else $error("Strobe level wrong.");
  AST_READ_DIR: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.phase != cdb_pkg::PH_IDLE && st_ff.op_rd) |-> display_rw && display_data_lines_oe == 8'h00)
    else $error("Data driven during read.");
  AST_DMA_REQ: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 dma_req == $past(st_ff.cfg[cdb_pkg::CFG_DMA_BIT] && !wr_pending)) else $error("DMA request wrong.");
  AST_NIBBLE_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
    (st_ff.phase == cdb_pkg::PH_ACTIVE && !bus8 && !st_ff.op_rd && !st_ff.nib)
    |-> display_data_lines_out[7:4] == st_ff.op_byte[7:4] && display_data_lines_oe == 8'hF0)
    else $error("Upper nibble not first.");

endmodule // cdb_display_master

// File: bench/cdb_display_model.sv
// Purpose: Display module stand-in that answers read cycles.
// Assumes: Strobe polarity is handed in on pol.
// Notes: Undriven data lines toggle every cycle.
`timescale 1ns/1ps
module cdb_display_model #(parameter logic [7:0] RVAL = 8'h5A) (
  // Pins.
  input wire logic       clk,
  input wire logic       pol,
  input wire logic       strobe,
  input wire logic       rw,
  output logic     [7:0] data
);
  initial data = 8'h00;
  // Drive the read byte only while a read strobe is active.
  always @(posedge clk) begin
    if (rw && strobe === pol) begin
      data <= RVAL;
    end else begin
      data <= ~data;
    end
  end
endmodule // cdb_display_model

// File: bench/char_display_bus_master_tb.sv
// Purpose: Self-checking bench for the display bus master.
// Assumes: Strobe pulses are captured as select, direction and data.
// Notes: Timings are set short before any command.
`timescale 1ns/1ps
module char_display_bus_master_tb;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pol = 0, prev = 0, err, dma_req, stb, rs, rw;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr;
  logic [7:0]  dout, doe, din, mdata, oe_seen;
  logic [9:0]  cap[$];
  int          errors = 0, n_compared = 0, cyc = 0;
  always #2.5 clk = ~clk;
  assign din = (doe & dout) | (~doe & mdata);
  cdb_display_master uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_req(dma_req),
    .display_strobe(stb), .display_reg_select(rs), .display_rw(rw), .display_data_lines_in(din),
    .display_data_lines_out(dout), .display_data_lines_oe(doe));
  cdb_display_model model (.clk(clk), .pol(pol), .strobe(stb), .rw(rw), .data(mdata));
  // Record select, direction and data at each strobe activation.
  always @(posedge clk) begin
    prev <= (stb === pol);
    if (stb === pol && !prev) begin
      cap.push_back({rs, rw, dout});
      oe_seen <= doe;
    end
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB access; result taken at the edge where pready is high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk) begin psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; end
    @(posedge clk) penable <= 1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Wait until the command bit clears before the next command.
  task automatic poll(input logic [11:0] a);
    int n;
    n = 0;
    do begin apb(0, a, 0); n++; end while (rd[9] !== 1'b0 && n < 200);
    if (rd[9] !== 1'b0) errors++;
  endtask
  task automatic finish_test();
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    apb(0, 12'h000, 0); chk(rd, 32'hFFFF_FF00);
    apb(0, 12'h00C, 0); chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1, 12'h000, 32'h0300_0007); apb(0, 12'h000, 0); chk(rd, 32'h0300_0007);
    pol = 1; cap.delete();
    apb(1, 12'h008, 32'h0000_03A5); apb(0, 12'h008, 0); chk(rd, 32'h0000_03A5);
    chk(dma_req, 0);
    poll(12'h008); chk(cap[0], 10'h2A5);
    chk(oe_seen, 8'hFF);
    repeat (40) @(posedge clk); chk(dma_req, 1);
    cap.delete();
    apb(1, 12'h004, 32'h0000_0200); apb(1, 12'h008, 32'h0000_0311); poll(12'h008);
    chk(rd, 32'h0000_0111); chk(cap[0][9:8], 2'b01); chk(cap[1], 10'h211);
    apb(0, 12'h004, 0); chk(rd, 32'h0000_005A);
    apb(1, 12'h000, 32'h0300_0004); pol = 0; repeat (4) @(posedge clk); cap.delete();
    apb(1, 12'h008, 32'h0000_02C3); poll(12'h008); chk(cap.size(), 2);
    chk(cap[0], 10'h0C0); chk(cap[1], 10'h030);
    chk(oe_seen, 8'hF0);
    repeat (2) @(posedge clk); chk(dma_req, 1);
    if (dma_req) apb(1, 12'h008, 32'h0000_0255);
    repeat (2) @(posedge clk); chk(dma_req, 0);
    poll(12'h008); chk(rd, 32'h0000_0055);
    finish_test();
  end
endmodule // char_display_bus_master_tb
